// [inc/fcs_regs.svh]
// Timing constants and option bit positions for the configuration sequencer.
// Assumes a 40 MHz ref_clk (25 ns period).
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH

`define FCS_CLK_PERIOD_NS 25
`define FCS_RECONFIG_MIN_NS 500
`define FCS_RECONFIG_MIN_CYC ((`FCS_RECONFIG_MIN_NS + `FCS_CLK_PERIOD_NS - 1) / `FCS_CLK_PERIOD_NS)
`define FCS_RESTART_TIMEOUT_US 230
`define FCS_RESTART_TIMEOUT_CYC ((`FCS_RESTART_TIMEOUT_US * 1000) / `FCS_CLK_PERIOD_NS)
`define FCS_INIT_CYCLES 3192
`define FCS_OPT_INIT_DONE_BIT 0
`define FCS_OPT_COMPRESSED_BIT 1
`define FCS_FIFO_DEPTH 8
`define FCS_FIFO_WIDTH 8

`endif

// [inc/fcs_pkg.sv]
// Types shared by the configuration sequencer files.
// Assumes fcs_regs.svh is on the include path.
package fcs_pkg;
   typedef enum logic [1:0] {
      FCS_SCHEME_ACTIVE_SERIAL,
      FCS_SCHEME_PASSIVE_SERIAL,
      FCS_SCHEME_ACTIVE_PARALLEL,
      FCS_SCHEME_FAST_PARALLEL
   } fcs_scheme_e;

   typedef enum {
      FCS_ST_RESET,
      FCS_ST_WAIT_RELEASE,
      FCS_ST_CONFIG,
      FCS_ST_ERROR,
      FCS_ST_INIT,
      FCS_ST_USER
   } fcs_state_e;

   typedef logic [7:0] fcs_byte_t;
endpackage

// [inc/fcs_stream_if.sv]
// Valid/ready byte stream between sequencer and its buffer.
// Assumes a single clock domain.
interface fcs_stream_if;
   logic valid;
   logic ready;
   logic [7:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// [design/fcs_fifo.sv]
// Parameterised flip-flop FIFO with valid/ready on both sides.
// Assumes synchronous, already released active-low reset.
module fcs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,  // Clock
   input wire logic rst_n,  // Released reset
   fcs_stream_if.snk wr,  // Fill side
   fcs_stream_if.src rd  // Drain side
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wp_ff, rp_ff;
   logic [AW:0] cnt_ff;
   wire full = (cnt_ff == (AW+1)'(DEPTH));
   wire empty = (cnt_ff == '0);
   wire do_wr = wr.valid && !full;
   wire do_rd = rd.ready && !empty;
   assign wr.ready = !full;
   assign rd.valid = !empty;
   assign rd.data = mem_ff[rp_ff];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (do_wr) wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
         if (do_rd) rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
         cnt_ff <= cnt_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end

   genvar i;
   generate
      for (i = 0; i < DEPTH; i++) begin : g_mem
         always_ff @(posedge clk) begin
            if (do_wr && wp_ff == AW'(i)) mem_ff[i] <= wr.data;
         end
      end
   endgenerate
endmodule // fcs_fifo

// [design/fcs_config_sequencer.sv]
// Configuration phase sequencer: reset, load, error/retry, init, user mode.
// Assumes all pins synchronous to ref_clk; bitstream arrives as bytes.
//
// Functional notes
// - While request low: reset, status and complete low, all I/O tri-stated.
// - Loading starts only after request high and status released.
// - Load error drives status low, complete stays low.
// - Auto-restart releases status within 230 us, then retries.
// - Default initialization clock is the internal oscillator.
// - With internal oscillator, start-up clock pin is ordinary user I/O.
// - With start-up clock option, init advances only on its edges.
// - Start-up clock affects the data load phase only as serial clock source on transceiver variant.
// - After complete goes high, count 3192 init clocks to user mode.
// - Init-done driven low after option bit loaded, released at user mode.
// - In user mode I/O follows design; weak pull-ups removed.
// - Chain enable out driven low once own data fully captured.
// - Last device chain enable out becomes user I/O after configuration.
// - Chained devices share request, status, complete, clock, data lines.
// - Both compressed and uncompressed bitstreams accepted.
// - Flash select doubles as parallel enable; command out as data bit 1.
// - Serial clock from start-up clock only on transceiver variant, 40 MHz.
// - Test-port configuration wins; active serial load terminated.
// - Active serial generates serial clock from internal oscillator.
`include "fcs_regs.svh"
module fcs_config_sequencer
   import fcs_pkg::*;
(
   input wire logic ref_clk,  // Internal oscillator, 40 MHz
   input wire logic resetn,  // Async reset, active low
   input wire logic reconfig_request_n,  // Reconfiguration request
   input wire logic config_status_n_in,  // Shared status line level
   output logic config_status_n_out,  // Status drive value
   output logic config_status_n_oe,  // Status drive enable
   input wire logic config_complete_in,  // Shared complete line level
   output logic config_complete_out,  // Complete drive value
   output logic config_complete_oe,  // Complete drive enable
   input wire logic [1:0] config_scheme_select,  // Scheme select straps
   input wire logic chain_enable_in_n,  // Chain enable from previous device
   output logic chain_enable_out_n,  // Chain enable to next device
   output logic chain_enable_out_oe,  // Chain enable drive enable
   input wire logic user_chain_out,  // User value for chain out pin
   input wire logic auto_restart_en,  // Auto-restart after error option
   input wire logic user_startup_clock_en,  // Start-up clock option
   input wire logic user_startup_clock,  // Start-up clock pin level
   output logic user_startup_clock_as_io,  // Pin free for user I/O
   input wire logic transceiver_variant,  // Transceiver-equipped variant
   input wire logic serial_config_clock_from_user_clock,  // Serial clock source select
   input wire logic test_port_config,  // Test-port configuration active
   output logic serial_config_clock,  // Generated serial clock
   output logic serial_flash_select_n,  // Flash select / parallel enable
   output logic serial_flash_command_out,  // Flash command / data bit 1
   input wire logic [7:0] bit_data,  // Bitstream byte
   input wire logic bit_valid,  // Bitstream byte valid
   output logic bit_ready,  // Bitstream byte ready
   input wire logic bit_last,  // Last byte of own bitstream
   input wire logic bit_error,  // Frame error with this byte
   output logic [7:0] cfg_data,  // Configuration byte to fabric
   output logic cfg_data_valid,  // Configuration byte valid
   input wire logic cfg_data_ready,  // Fabric accepts byte
   output logic init_done_n,  // Init-done drive low, active
   output logic init_done_oe,  // Init-done drive enable
   output logic io_tristate,  // All user I/O tri-stated
   output logic weak_pullup_en,  // Weak pull-ups on user I/O
   output logic user_mode,  // Device in user mode
   output logic compressed  // Bitstream flagged compressed
);
   // ***********************************************************
   // Reset release
   // ***********************************************************
   logic rst_s1_ff, rst_n;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1_ff <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_n <= rst_s1_ff;
      end
   end

   // ***********************************************************
   // Start-up clock edge detect
   // ***********************************************************
   logic usr_clk_d_ff;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) usr_clk_d_ff <= 1'b0;
      else usr_clk_d_ff <= user_startup_clock;
   end
   wire usr_clk_rise = user_startup_clock && !usr_clk_d_ff;
   wire init_tick = user_startup_clock_en ? usr_clk_rise : 1'b1;
   assign user_startup_clock_as_io = !user_startup_clock_en;

   // ***********************************************************
   // Scheme decode
   // ***********************************************************
   fcs_scheme_e scheme;
   assign scheme = fcs_scheme_e'(config_scheme_select);
   wire is_as = (scheme == FCS_SCHEME_ACTIVE_SERIAL);
   wire is_par = (scheme == FCS_SCHEME_ACTIVE_PARALLEL) || (scheme == FCS_SCHEME_FAST_PARALLEL);
   wire as_abort = is_as && test_port_config;

   // ***********************************************************
   // Sequencer
   // ***********************************************************
   fcs_state_e state_ff, nxt_state;
   logic [13:0] cnt_ff, nxt_cnt;
   logic first_ff, nxt_first;
   logic init_opt_ff, nxt_init_opt;
   logic comp_ff, nxt_comp;
   logic captured_ff, nxt_captured;
   logic last_seen_ff, nxt_last_seen;

   fcs_stream_if in_s ();
   fcs_stream_if out_s ();

   wire req_low = !reconfig_request_n;
   wire own_turn = !chain_enable_in_n;
   wire accept = (state_ff == FCS_ST_CONFIG) && own_turn && bit_valid && in_s.ready;
   wire fifo_drained = !out_s.valid;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_first = first_ff;
      nxt_init_opt = init_opt_ff;
      nxt_comp = comp_ff;
      nxt_captured = captured_ff;
      nxt_last_seen = last_seen_ff;
      if (req_low) begin
         nxt_state = FCS_ST_RESET;
         nxt_cnt = '0;
      end else begin
         case (state_ff)
            FCS_ST_RESET: begin
               nxt_first = 1'b1;
               nxt_init_opt = 1'b0;
               nxt_comp = 1'b0;
               nxt_captured = 1'b0;
               nxt_last_seen = 1'b0;
               nxt_state = FCS_ST_WAIT_RELEASE;
            end
            FCS_ST_WAIT_RELEASE: begin
               if (config_status_n_in) nxt_state = FCS_ST_CONFIG;
            end
            FCS_ST_CONFIG: begin
               if (as_abort) begin
                  nxt_state = FCS_ST_RESET;
               end else if (accept && bit_error) begin
                  nxt_state = FCS_ST_ERROR;
                  nxt_cnt = '0;
               end else begin
                  if (accept) begin
                     nxt_first = 1'b0;
                     if (first_ff) begin
                        nxt_init_opt = bit_data[`FCS_OPT_INIT_DONE_BIT];
                        nxt_comp = bit_data[`FCS_OPT_COMPRESSED_BIT];
                     end
                     if (bit_last) begin
                        nxt_last_seen = 1'b1;
                        nxt_captured = 1'b1;
                     end
                  end
                  if (last_seen_ff && fifo_drained && config_complete_in) begin
                     nxt_state = FCS_ST_INIT;
                     nxt_cnt = '0;
                  end
               end
            end
            FCS_ST_ERROR: begin
               if (auto_restart_en) begin
                  nxt_cnt = cnt_ff + 14'h0001;
                  if (cnt_ff == 14'(`FCS_RESTART_TIMEOUT_CYC - 1)) begin
                     nxt_state = FCS_ST_RESET;
                  end
               end
            end
            FCS_ST_INIT: begin
               if (init_tick) begin
                  nxt_cnt = cnt_ff + 14'h0001;
                  if (cnt_ff == 14'(`FCS_INIT_CYCLES - 1)) nxt_state = FCS_ST_USER;
               end
            end
            FCS_ST_USER: begin
               nxt_state = FCS_ST_USER;
            end
            default: nxt_state = FCS_ST_RESET;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= FCS_ST_RESET;
         cnt_ff <= '0;
         first_ff <= 1'b1;
         init_opt_ff <= 1'b0;
         comp_ff <= 1'b0;
         captured_ff <= 1'b0;
         last_seen_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         first_ff <= nxt_first;
         init_opt_ff <= nxt_init_opt;
         comp_ff <= nxt_comp;
         captured_ff <= nxt_captured;
         last_seen_ff <= nxt_last_seen;
      end
   end

   // ***********************************************************
   // Bitstream buffer
   // ***********************************************************
   assign in_s.valid = accept && !bit_error;
   assign in_s.data = bit_data;
   assign bit_ready = (state_ff == FCS_ST_CONFIG) && own_turn && in_s.ready;
   assign out_s.ready = cfg_data_ready;

   fcs_fifo #(
      .WIDTH(`FCS_FIFO_WIDTH),
      .DEPTH(`FCS_FIFO_DEPTH)
   ) u_fifo (
      .clk(ref_clk),
      .rst_n(rst_n),
      .wr(in_s),
      .rd(out_s)
   );

   logic [7:0] cfg_data_ff;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) cfg_data_ff <= 8'h00;
      else if (out_s.valid && cfg_data_ready) cfg_data_ff <= out_s.data;
   end
   assign cfg_data = cfg_data_ff;
   assign cfg_data_valid = out_s.valid;

   // ***********************************************************
   // Pin drive
   // ***********************************************************
   wire in_reset = req_low || (state_ff == FCS_ST_RESET);
   wire in_error = (state_ff == FCS_ST_ERROR);
   wire done_ok = (state_ff == FCS_ST_INIT) || (state_ff == FCS_ST_USER);
   assign config_status_n_out = 1'b0;
   assign config_status_n_oe = in_reset || in_error;
   assign config_complete_out = 1'b0;
   // Released only once own data is in; line goes high when whole chain is done
   assign config_complete_oe = in_reset || (!(last_seen_ff && fifo_drained) && !done_ok);
   assign user_mode = (state_ff == FCS_ST_USER);
   assign io_tristate = !user_mode;
   assign weak_pullup_en = !user_mode && !req_low;
   assign init_done_n = 1'b0;
   assign init_done_oe = init_opt_ff && !first_ff && !user_mode && !in_reset;
   assign chain_enable_out_n = user_mode ? user_chain_out : !captured_ff;
   assign chain_enable_out_oe = !in_reset;
   assign compressed = comp_ff;

   // ***********************************************************
   // Serial clock and flash pins
   // ***********************************************************
   logic serial_config_clock_ff;
   wire loading = (state_ff == FCS_ST_CONFIG) && own_turn && !as_abort;
   wire use_usr = transceiver_variant && serial_config_clock_from_user_clock;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) serial_config_clock_ff <= 1'b0;
      else serial_config_clock_ff <= loading && is_as && !serial_config_clock_ff;
   end
   assign serial_config_clock = use_usr ? (loading && is_as && user_startup_clock) : serial_config_clock_ff;
   assign serial_flash_select_n = !(loading && (is_as || is_par));
   assign serial_flash_command_out = is_par ? bit_data[1] : 1'b0;
endmodule // fcs_config_sequencer

// [test/fcs_config_sequencer_monitor.sv]
// Concurrent checks on the configuration sequencer ports.
// Assumes it is bound into fcs_config_sequencer.
module fcs_config_sequencer_monitor (
   input wire logic ref_clk, // Clock
   input wire logic resetn, // Reset
   input wire logic reconfig_request_n, // In
   input wire logic config_status_n_in, // In
   input wire logic config_status_n_oe, // Out
   input wire logic config_complete_oe, // Out
   input wire logic [1:0] config_scheme_select, // In
   input wire logic chain_enable_out_n, // Out
   input wire logic user_chain_out, // In
   input wire logic auto_restart_en, // In
   input wire logic user_startup_clock_en, // In
   input wire logic user_startup_clock, // In
   input wire logic user_startup_clock_as_io, // Out
   input wire logic serial_flash_command_out, // Out
   input wire logic [7:0] bit_data, // In
   input wire logic bit_valid, // In
   input wire logic bit_ready, // Out
   input wire logic bit_last, // In
   input wire logic bit_error, // In
   input wire logic init_done_oe, // Out
   input wire logic io_tristate, // Out
   input wire logic weak_pullup_en, // Out
   input wire logic user_mode // Out
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****
   // Helper counters
   // ****
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   logic [13:0] init_cnt_ff, err_cnt_ff;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         init_cnt_ff <= 14'h0;
         err_cnt_ff <= 14'h0;
      end else begin
         init_cnt_ff <= config_complete_oe ? 14'h0 : init_cnt_ff + 14'h1;
         err_cnt_ff <= (config_status_n_oe && reconfig_request_n) ? err_cnt_ff + 14'h1 : 14'h0;
      end
   end
   // ****
   // Assertions
   // ****
   sequence s_take;
      bit_valid && bit_ready;
   endsequence
   a_req_resets: assert property (!reconfig_request_n |=>
      config_status_n_oe && config_complete_oe && io_tristate && !user_mode)
      else $error("request low did not reset outputs");
   a_err_report: assert property (s_take ##0 bit_error |=>
      config_status_n_oe && config_complete_oe) else $error("error not reported");
   a_retry_bound: assert property (auto_restart_en |-> err_cnt_ff <= 14'h23F2)
      else $error("status held past restart timeout");
   a_init_count: assert property ($rose(user_mode) && !user_startup_clock_en |->
      init_cnt_ff >= 14'hC76 && init_cnt_ff <= 14'hC7A) else $error("init count wrong");
   a_done_release: assert property ($rose(user_mode) |-> !init_done_oe)
      else $error("init done not released");
   a_io_user: assert property (io_tristate == !user_mode &&
      weak_pullup_en == (!user_mode && reconfig_request_n)) else $error("io state wrong");
   a_clk_pin_io: assert property (user_startup_clock_as_io == !user_startup_clock_en)
      else $error("clock pin io wrong");
   a_chain_done: assert property (s_take ##0 (bit_last && !bit_error) |=>
      !chain_enable_out_n) else $error("chain out not low");
   a_chain_user: assert property (user_mode && $stable(user_chain_out) |->
      chain_enable_out_n == user_chain_out) else $error("chain out not user io");
   a_flash_dual: assert property (serial_flash_command_out ==
      (config_scheme_select[1] && bit_data[1])) else $error("command out wrong");
   a_wait_status: assert property (!config_status_n_in |-> !bit_ready)
      else $error("load while status low");
   a_user_clk_hold: assert property ((user_startup_clock_en &&
      $stable(user_startup_clock))[*6] |=> !$rose(user_mode)) else $error("init without tick");
endmodule // fcs_config_sequencer_monitor

// [test/fcs_cfg_memory.sv]
// Serial configuration memory model streaming bitstream bytes.
// Assumes go is high for one cycle with the job fields steady.
module fcs_cfg_memory (
   input wire logic ref_clk, // Clock
   input wire logic go, // Start
   input wire logic slow, // Idle after each byte
   input wire logic [7:0] nbytes, // Length
   input wire logic [7:0] err_at, // Bad byte index
   input wire logic [7:0] first_byte, // Option byte
   input wire logic [7:0] base, // Payload seed
   input wire logic bit_ready, // Taken
   output logic [7:0] bit_data, // Byte
   output logic bit_valid, // Valid
   output logic bit_last, // Final
   output logic bit_error, // Frame error
   output logic busy // Running
);
   timeunit 1ns;
   timeprecision 100ps;
   int i, k;
   initial begin
      {bit_valid, bit_last, bit_error, busy} = 4'h0;
      bit_data = 8'h5A;
      forever begin
         @(posedge ref_clk);
         if (go) begin
            busy <= 1'b1;
            for (i = 0; i < nbytes; i++) begin
               bit_valid <= 1'b1;
               bit_data <= (i == 0) ? first_byte : base + 8'(i);
               bit_last <= (i == nbytes - 1);
               bit_error <= (i == err_at);
               k = 0;
               do begin
                  @(posedge ref_clk);
                  k++;
               end while (!bit_ready && k < 20000);
               if (i == err_at) break;
               if (slow) begin
                  bit_valid <= 1'b0;
                  bit_data <= ~bit_data;
                  @(posedge ref_clk);
               end
            end
            {bit_valid, bit_last, bit_error, busy} <= 4'h0;
            bit_data <= ~bit_data;
         end
      end
   end
endmodule // fcs_cfg_memory

// [test/fcs_config_sequencer_tb.sv]
// Self-checking bench for the configuration sequencer.
// Assumes the design, FIFO, package and memory model are compiled first.
module fcs_config_sequencer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 0, resetn = 0, reconfig_request_n = 1, chain_enable_in_n = 0;
   logic user_chain_out = 0, auto_restart_en = 0, user_startup_clock_en = 0;
   logic user_startup_clock = 0, transceiver_variant = 0, serial_config_clock_from_user_clock = 0;
   logic test_port_config = 0, cfg_data_ready = 1, go = 0, slow = 0, busy, pop_seen = 0;
   logic [1:0] config_scheme_select = 2'h0;
   logic [7:0] nbytes = 8'h0, err_at = 8'hFF, first_byte = 8'h0, base = 8'h0;
   logic [7:0] bit_data, cfg_data;
   logic bit_valid, bit_ready, bit_last, bit_error, cfg_data_valid, compressed, user_mode;
   logic config_status_n_out, config_status_n_oe, config_complete_out, config_complete_oe;
   logic chain_enable_out_n, chain_enable_out_oe, user_startup_clock_as_io;
   logic serial_config_clock, serial_flash_select_n, serial_flash_command_out;
   logic init_done_n, init_done_oe, io_tristate, weak_pullup_en;
   wire config_status_n_in = config_status_n_oe ? config_status_n_out : 1'b1;
   wire config_complete_in = config_complete_oe ? config_complete_out : 1'b1;
   int bad_count = 0, samples_checked = 0, n, acc_cnt = 0;
   logic [7:0] exp_q[$];
   fcs_config_sequencer fcs_config_sequencer_i (.*);
   fcs_cfg_memory fcs_cfg_memory_i (.*);
   always #12.5 ref_clk = ~ref_clk;
   // ****
   // Tasks
   // ****
   task automatic tick(int c);
      repeat (c) @(posedge ref_clk);
   endtask
   task automatic usr_ticks(int c);
      repeat (c) begin
         user_startup_clock <= 1'b1;
         tick(2);
         user_startup_clock <= 1'b0;
         tick(2);
      end
   endtask
   task automatic chk_val(string what, logic [15:0] got, logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_byte(string what, logic [7:0] got, logic [7:0] exp);
      chk_val(what, {8'h0, got}, {8'h0, exp});
   endtask
   task automatic pulse_req;
      reconfig_request_n <= 1'b0;
      tick(3);
      chk_val("reset drive", {io_tristate, config_status_n_oe, config_complete_oe, user_mode,
         chain_enable_out_oe}, 16'h1C);
      repeat (16) begin
         user_startup_clock <= ~user_startup_clock;
         tick(1);
      end
      user_startup_clock <= 1'b0;
      tick(1);
      reconfig_request_n <= 1'b1;
      exp_q.delete();
   endtask
   task automatic start(int nb, int ea, logic [7:0] fb);
      nbytes <= 8'(nb);
      err_at <= 8'(ea);
      first_byte <= fb;
      base <= 8'($urandom);
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      tick(1);
   endtask
   task automatic finish;
      for (int k = 0; k < 5000 && busy; k++) tick(1);
      tick(1);
   endtask
   task automatic wait_user(output int c);
      c = 0;
      for (int k = 0; k < 5000 && config_complete_oe; k++) tick(1);
      while (!user_mode && c < 20000) begin
         tick(1);
         c++;
      end
   endtask
   task give_verdict;
      $display("Checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ****
   // Scoreboard and tests
   // ****
   always @(posedge ref_clk) begin
      if (pop_seen && exp_q.size() != 0) chk_byte("cfg_data", cfg_data, exp_q.pop_front());
      pop_seen = cfg_data_valid && cfg_data_ready;
      if (bit_valid && bit_ready && !bit_error) begin
         exp_q.push_back(bit_data);
         acc_cnt++;
      end
   end
   initial begin
      tick(90000);
      bad_count++;
      give_verdict;
   end
   initial begin
      void'($urandom(32'hACA3));
      tick(12);
      resetn <= 1'b1;
      tick(3);
      start(6, 255, 8'h01);
      finish;
      chk_val("chain out", chain_enable_out_n, 0);
      chk_val("init done oe", init_done_oe, 1);
      chk_val("compressed", compressed, 0);
      wait_user(n);
      chk_val("init cycles", n >= 3190 && n <= 3194, 1);
      chk_val("user io", {io_tristate, weak_pullup_en, init_done_oe}, 0);
      user_chain_out <= 1'b1;
      tick(2);
      chk_val("chain user", chain_enable_out_n, 1);
      $display("Test plain load done");
      pulse_req;
      config_scheme_select <= 2'h1;
      start(4, 255, 8'h00);
      finish;
      tick(200);
      pulse_req;
      tick(8);
      chk_val("aborted init", {user_mode, bit_ready}, 1);
      $display("Test init abort done");
      config_scheme_select <= 2'h2;
      start(5, 2, 8'h02);
      finish;
      chk_val("compressed", compressed, 1);
      tick(300);
      chk_val("error hold", {config_status_n_oe, config_complete_oe, bit_ready}, 6);
      pulse_req;
      $display("Test error hold done");
      auto_restart_en <= 1'b1;
      config_scheme_select <= 2'h3;
      start(5, 1, 8'h00);
      finish;
      for (n = 0; n < 12000 && config_status_n_oe; n++) tick(1);
      chk_val("restart wait", n > 0 && n <= 9202, 1);
      tick(6);
      chk_val("retry ready", bit_ready, 1);
      start(3, 255, 8'h00);
      finish;
      wait_user(n);
      chk_val("user after retry", user_mode, 1);
      auto_restart_en <= 1'b0;
      $display("Test auto restart done");
      pulse_req;
      config_scheme_select <= 2'h0;
      user_startup_clock_en <= 1'b1;
      start(3, 255, 8'h01);
      finish;
      chk_val("clock pin io", user_startup_clock_as_io, 0);
      tick(4000);
      chk_val("held by clock", {user_mode, config_complete_oe}, 0);
      usr_ticks(100);
      pulse_req;
      start(3, 255, 8'h01);
      finish;
      usr_ticks(3191);
      chk_val("init restarted", user_mode, 0);
      usr_ticks(9);
      chk_val("user by clock", user_mode, 1);
      user_startup_clock_en <= 1'b0;
      $display("Test start-up clock done");
      pulse_req;
      cfg_data_ready <= 1'b0;
      slow <= 1'b1;
      acc_cnt = 0;
      start(12, 255, 8'h00);
      tick(60);
      chk_val("fifo fill", acc_cnt, 8);
      chk_val("fifo full ready", bit_ready, 0);
      chk_val("flash select", serial_flash_select_n, 0);
      n = serial_config_clock;
      tick(1);
      chk_val("serial clock", serial_config_clock, !n);
      {transceiver_variant, serial_config_clock_from_user_clock, user_startup_clock} <= 3'h7;
      tick(2);
      chk_val("clock from pin", serial_config_clock, 1);
      user_startup_clock <= 1'b0;
      tick(2);
      chk_val("clock pin low", serial_config_clock, 0);
      {transceiver_variant, serial_config_clock_from_user_clock} <= 2'h0;
      test_port_config <= 1'b1;
      tick(2);
      chk_val("test port abort", {config_status_n_oe, serial_flash_select_n}, 3);
      test_port_config <= 1'b0;
      repeat (80) begin
         cfg_data_ready <= 1'($urandom);
         tick(1);
      end
      cfg_data_ready <= 1'b1;
      finish;
      tick(20);
      chk_val("fifo drained", {cfg_data_valid, exp_q.size() != 0}, 0);
      $display("Test buffer done");
      give_verdict;
   end
endmodule // fcs_config_sequencer_tb
bind fcs_config_sequencer fcs_config_sequencer_monitor fcs_config_sequencer_monitor_i (.*);
